// ===== design/sdr_defines.svh
`ifndef SDR_DEFINES_SVH
`define SDR_DEFINES_SVH

// system clock rate in MHz (period 4 ns)
`define SDR_CLK_MHZ 250
// least time the supply must stay below the trip threshold, in ns
`define SDR_MIN_DROP_NS 2000
// start-up time-out after the supply recovers, in ns
`define SDR_STARTUP_NS 4000000
// derived cycle counts, both rounded up since both are least times
`define SDR_MIN_DROP_CYC ((`SDR_MIN_DROP_NS*`SDR_CLK_MHZ+999)/1000)
`define SDR_STARTUP_CYC ((`SDR_STARTUP_NS*`SDR_CLK_MHZ+999)/1000)

// trip-level select field
`define SDR_SEL_W 3
`define SDR_SEL_MSB 2
`define SDR_LVL_W 2
`define SDR_SEL_OFF 3'h7
`define SDR_SEL_RESET 3'h7

`endif

// ===== design/sdr_pkg.sv
`include "sdr_defines.svh"

package sdr_pkg;

   typedef logic [`SDR_SEL_W-1:0] sdr_sel_t;
   typedef logic [`SDR_LVL_W-1:0] sdr_lvl_t;

   // sequencer states
   typedef enum logic [1:0] {
      ST_RUN,
      ST_DROP,
      ST_DELAY
   } sdr_state_t;

   // decoded trip-level setting
   typedef struct packed {
      logic enable;
      logic reserved;
      sdr_lvl_t level;
   } sdr_cfg_t;

   // 111 off, 110..100 reserved (kept off), 011..000 one level each
   function automatic sdr_cfg_t sdr_decode(input sdr_sel_t sel);
      sdr_cfg_t cfg;
      cfg.enable = ~sel[`SDR_SEL_MSB];
      cfg.reserved = sel[`SDR_SEL_MSB] & (sel != `SDR_SEL_OFF);
      cfg.level = sel[`SDR_LVL_W-1:0];
      return cfg;
   endfunction

endpackage

// ===== design/sdr_drop_if.sv
`timescale 1ns/1ps

// comparator path between the sequencer and the drop filter
interface sdr_drop_if;
   logic below_raw;
   logic enable;
   logic below_now;
   logic drop_seen;

   modport filt (
      input below_raw,
      input enable,
      output below_now,
      output drop_seen
   );

   modport ctl (
      output below_raw,
      output enable,
      input below_now,
      input drop_seen
   );
endinterface

// ===== design/sdr_drop_filter.sv
`timescale 1ns/1ps
`include "sdr_defines.svh"

module sdr_drop_filter #(
   parameter int MIN_CYC = `SDR_MIN_DROP_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   sdr_drop_if.filt link
);
   import sdr_pkg::*;

   localparam int CW = $clog2(MIN_CYC + 1);
   localparam logic [CW-1:0] MIN_C = CW'(MIN_CYC);

   logic s1_ff, s2_ff, s3_ff, lvl_ff, drop_ff;
   logic [CW-1:0] cnt_ff;
   logic nxt_lvl, nxt_drop, cnt_full, active;
   logic [CW-1:0] nxt_cnt;

   // a change only counts once the last two stages agree
   assign nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
   assign active = link.enable & lvl_ff;
   assign cnt_full = (cnt_ff == MIN_C);
   // short dips clear the count, so they never qualify
   assign nxt_cnt = !active ? '0 : cnt_full ? cnt_ff : cnt_ff + 1'b1;
   assign nxt_drop = active & cnt_full;

   // three-stage synchroniser for the comparator output
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         lvl_ff <= 1'b0;
      end else begin
         s1_ff <= link.below_raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   // duration counter
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= '0;
         drop_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         drop_ff <= nxt_drop;
      end
   end

   assign link.below_now = lvl_ff;
   assign link.drop_seen = drop_ff;

   a_drop_after_min: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(drop_ff) |-> $past(cnt_ff) == MIN_C && $past(lvl_ff))
      else $error("drop qualified before the minimum duration");

   a_dip_clears_count: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !lvl_ff |=> cnt_ff == '0 && !drop_ff)
      else $error("count or drop kept after the supply recovered");

   a_off_no_drop: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !link.enable |=> !drop_ff)
      else $error("drop raised while detection is off");
endmodule

// ===== design/sdr_top.sv
`timescale 1ns/1ps
`include "sdr_defines.svh"

module sdr_top #(
   parameter int MIN_DROP_CYC = `SDR_MIN_DROP_CYC,
   parameter int STARTUP_CYC = `SDR_STARTUP_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire sdr_pkg::sdr_sel_t trip_level_select_i,
   input wire logic below_trip_i,
   input wire logic nv_write_busy_i,
   output sdr_pkg::sdr_lvl_t trip_threshold_o,
   output logic supply_drop_detector_en_o,
   output logic level_reserved_o,
   output logic chip_reset_b_o,
   output logic nv_reset_b_o
);
   import sdr_pkg::*;

   localparam int DW = $clog2(STARTUP_CYC + 1);
   localparam logic [DW-1:0] DLY_LAST = DW'(STARTUP_CYC - 1);

   sdr_drop_if drop_link ();

   // fuse select synchroniser and the accepted setting
   sdr_sel_t sel_s1_ff, sel_s2_ff, sel_s3_ff, sel_ff, nxt_sel;
   sdr_cfg_t cfg;

   // sequencer state
   sdr_state_t state_ff, nxt_state;
   logic [DW-1:0] dly_cnt_ff, nxt_dly_cnt;
   logic dly_done, recovered;

   // output registers
   sdr_lvl_t thr_ff;
   logic det_en_ff, rsvd_ff, chip_rst_b_ff, nv_rst_b_ff;
   logic nxt_chip_rst_b, nxt_nv_rst_b;

   // the setting is a static strap in practice, but it still crosses in
   // from outside, so it is only taken once the last two stages agree
   assign nxt_sel = (sel_s2_ff == sel_s3_ff) ? sel_s3_ff : sel_ff;
   assign cfg = sdr_decode(sel_ff);

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sel_s1_ff <= `SDR_SEL_RESET;
         sel_s2_ff <= `SDR_SEL_RESET;
         sel_s3_ff <= `SDR_SEL_RESET;
         sel_ff <= `SDR_SEL_RESET;
      end else begin
         sel_s1_ff <= trip_level_select_i;
         sel_s2_ff <= sel_s1_ff;
         sel_s3_ff <= sel_s2_ff;
         sel_ff <= nxt_sel;
      end
   end

   // comparator path; the filter sees the enable so a disabled
   // detector can never raise a drop
   assign drop_link.below_raw = below_trip_i;
   assign drop_link.enable = cfg.enable;

   sdr_drop_filter #(
      .MIN_CYC(MIN_DROP_CYC)
   ) u_filter (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .link(drop_link)
   );

   // recovery also counts when detection is switched off mid-drop,
   // otherwise the chip could stay in reset for good
   assign recovered = !drop_link.below_now | !cfg.enable;
   assign dly_done = (dly_cnt_ff == DLY_LAST);

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_dly_cnt = dly_cnt_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (drop_link.drop_seen) begin
               nxt_state = ST_DROP;
            end
            nxt_dly_cnt = '0;
         end
         ST_DROP: begin
            nxt_dly_cnt = '0;
            if (recovered) begin
               nxt_state = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (drop_link.drop_seen) begin
               nxt_state = ST_DROP;
               nxt_dly_cnt = '0;
            end else if (dly_done) begin
               nxt_state = ST_RUN;
               nxt_dly_cnt = '0;
            end else begin
               nxt_dly_cnt = dly_cnt_ff + 1'b1;
            end
         end
         // an upset code falls back to a full delay with reset held
         default: begin
            nxt_state = ST_DELAY;
            nxt_dly_cnt = '0;
         end
      endcase
   end

   // chip reset follows the next state so a drop acts on the next edge
   assign nxt_chip_rst_b = (nxt_state == ST_RUN);
   // once released, the nv reset stays released while a write runs, so
   // a write in flight is finished rather than cut short
   assign nxt_nv_rst_b = nxt_chip_rst_b |
                         (nv_rst_b_ff & nv_write_busy_i);

   // sequencer registers; power-up starts in the delay so the core only
   // leaves reset after one full time-out
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= ST_DELAY;
         dly_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         dly_cnt_ff <= nxt_dly_cnt;
      end
   end

   // output registers
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         thr_ff <= '0;
         det_en_ff <= 1'b0;
         rsvd_ff <= 1'b0;
         chip_rst_b_ff <= 1'b0;
         nv_rst_b_ff <= 1'b0;
      end else begin
         thr_ff <= cfg.level;
         det_en_ff <= cfg.enable;
         rsvd_ff <= cfg.reserved;
         chip_rst_b_ff <= nxt_chip_rst_b;
         nv_rst_b_ff <= nxt_nv_rst_b;
      end
   end

   assign trip_threshold_o = thr_ff;
   assign supply_drop_detector_en_o = det_en_ff;
   assign level_reserved_o = rsvd_ff;
   assign chip_reset_b_o = chip_rst_b_ff;
   assign nv_reset_b_o = nv_rst_b_ff;

   // helper: cycles spent in the delay state since it was last entered
   logic [DW:0] chk_dly_ff;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chk_dly_ff <= '0;
      end else if (state_ff == ST_DELAY) begin
         chk_dly_ff <= chk_dly_ff + 1'b1;
      end else begin
         chk_dly_ff <= '0;
      end
   end

   a_sel_decode_off: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      sel_ff[`SDR_SEL_MSB] |=> !supply_drop_detector_en_o)
      else $error("detector enabled by an off or reserved setting");

   a_sel_decode_on: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !sel_ff[`SDR_SEL_MSB] |=> supply_drop_detector_en_o &&
         trip_threshold_o == $past(sel_ff[`SDR_LVL_W-1:0]))
      else $error("trip level not taken from the setting");

   a_drop_resets_now: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      drop_link.drop_seen |=> !chip_reset_b_o &&
         (state_ff == ST_DROP || $past(state_ff) == ST_DROP))
      else $error("drop did not assert reset on the next edge");

   a_drop_holds_reset: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_ff == ST_DROP && !recovered |=> !chip_reset_b_o)
      else $error("reset released while the supply is low");

   a_delay_full_time: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $rose(chip_reset_b_o) |->
         chk_dly_ff == (DW+1)'(STARTUP_CYC))
      else $error("reset released before the full time-out");

   a_delay_restarts: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_ff == ST_DELAY && drop_link.drop_seen |=>
         dly_cnt_ff == '0 && !chip_reset_b_o ##1 !chip_reset_b_o)
      else $error("delay not restarted by a new drop");

   a_nv_write_kept: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      nv_reset_b_o && nv_write_busy_i |=> nv_reset_b_o)
      else $error("nv write cut short by reset");

   a_nv_follows_chip: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      chip_reset_b_o |-> nv_reset_b_o)
      else $error("nv reset held while the chip runs");

   a_nv_stays_low: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !nv_reset_b_o && state_ff == ST_DROP |=> !nv_reset_b_o)
      else $error("nv reset released during a supply drop");

   a_rsvd_kept_off: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      level_reserved_o |-> !supply_drop_detector_en_o)
      else $error("reserved setting left the detector on");

   a_delay_holds_reset: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_ff == ST_DELAY && !dly_done |=> !chip_reset_b_o)
      else $error("reset released before the delay ran out");

   a_run_stays_up: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      state_ff == ST_RUN && !drop_link.drop_seen |=> chip_reset_b_o)
      else $error("reset asserted with no qualified drop");
endmodule

// ===== tb/sdr_supply_model.sv
`timescale 1ns/1ps

// analogue comparator stand-in: output high while the supply is below
// the trip threshold; a dip lasts a whole number of clock cycles
module sdr_supply_model (
   input wire logic clk_sys_i,
   input wire logic dip_go_i,
   input wire logic [15:0] dip_len_i,
   output logic below_trip_o
);
   logic [15:0] left_ff = 16'h0;

   // count the dip down; the output is a level, never a pulse
   always @(posedge clk_sys_i) begin
      if (dip_go_i) begin
         left_ff <= dip_len_i;
      end else if (left_ff != 16'h0) begin
         left_ff <= left_ff - 16'h1;
      end
   end

   assign below_trip_o = (left_ff != 16'h0);
endmodule

// ===== tb/supply_drop_reset_bench.sv
`timescale 1ns/1ps

module supply_drop_reset_bench;
   import sdr_pkg::*;
   // short counts keep the run small; the delay is kept well above the
   // drop filter so that a restarted delay is told apart from a late one
   localparam int MD = 3;
   localparam int SU = 16;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   sdr_sel_t sel = 3'h0;
   logic busy = 1'b0;
   logic go = 1'b0;
   logic [15:0] len = 16'h0;
   logic below;
   sdr_lvl_t thr;
   logic en, rsv, chip_b, nv_b;
   int num_errors = 0;
   int checked = 0;

   always #2 clk_sys_i = ~clk_sys_i;

   sdr_top #(.MIN_DROP_CYC(MD), .STARTUP_CYC(SU)) u_dut (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .trip_level_select_i(sel),
      .below_trip_i(below),
      .nv_write_busy_i(busy),
      .trip_threshold_o(thr),
      .supply_drop_detector_en_o(en),
      .level_reserved_o(rsv),
      .chip_reset_b_o(chip_b),
      .nv_reset_b_o(nv_b)
   );

   sdr_supply_model u_model (
      .clk_sys_i(clk_sys_i),
      .dip_go_i(go),
      .dip_len_i(len),
      .below_trip_o(below)
   );

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // sample on the falling edge so the rising edge's updates have landed
   task automatic expect_rst(input int n, input logic exp);
      repeat (n) begin
         @(negedge clk_sys_i);
         check("chip_reset_b", chip_b, exp);
      end
   endtask

   task automatic dip(input int n);
      @(posedge clk_sys_i);
      go <= 1'b1;
      len <= n[15:0];
      @(posedge clk_sys_i);
      go <= 1'b0;
   endtask

   task automatic t_power_up;
      idle(16);
      check("chip_reset_b in reset", chip_b, 1'b0);
      rst_b_i <= 1'b1;
      // the release edge itself is still in reset; SU delay edges follow
      expect_rst(SU, 1'b0);
      expect_rst(1, 1'b1);
      $display("power up done");
   endtask

   // every setting, reserved ones included
   task automatic t_decode;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_i);
         sel <= i[2:0];
         idle(7);
         check("enable", en, !i[2]);
         check("reserved", rsv, i[2] & (i[1:0] != 2'h3));
         check("threshold", thr, i[1:0]);
      end
      sel <= 3'h0;
      idle(7);
      $display("decode done");
   endtask

   // a dip exactly the filter length is still too short
   task automatic t_short_dip;
      dip(MD);
      expect_rst(20, 1'b1);
      $display("short dip done");
   endtask

   // pin low 20 cycles; level falls 4 edges after it, delay starts one later
   task automatic t_long_dip;
      dip(20);
      idle(MD + 8);
      expect_rst(20 + SU - MD - 3, 1'b0);
      expect_rst(1, 1'b1);
      $display("long dip done");
   endtask

   // second drop lands during the delay; the delay must start over
   task automatic t_restart;
      dip(20);
      idle(MD + 8);
      expect_rst(21 - MD - 8, 1'b0);
      dip(20);
      expect_rst(20 + SU + 5, 1'b0);
      expect_rst(1, 1'b1);
      $display("restart done");
   endtask

   task automatic t_disabled;
      @(posedge clk_sys_i);
      sel <= 3'h7;
      idle(7);
      dip(20);
      expect_rst(30, 1'b1);
      @(posedge clk_sys_i);
      sel <= 3'h0;
      idle(7);
      $display("disabled done");
   endtask

   task automatic t_nv_hold;
      @(posedge clk_sys_i);
      busy <= 1'b1;
      dip(20);
      idle(MD + 8);
      check("chip_reset_b nv", chip_b, 1'b0);
      check("nv_reset_b busy", nv_b, 1'b1);
      busy <= 1'b0;
      idle(2);
      check("nv_reset_b idle", nv_b, 1'b0);
      idle(20 + SU + 10);
      check("nv_reset_b after", nv_b, 1'b1);
      $display("nv hold done");
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      t_power_up();
      t_decode();
      t_short_dip();
      t_long_dip();
      t_restart();
      t_disabled();
      t_nv_hold();
      report_and_stop();
   end

   // the tests take well under 1000 cycles
   initial begin
      idle(5000);
      num_errors++;
      $display("watchdog expired");
      report_and_stop();
   end
endmodule
